// ===== logic/dcs_sequencer.sv
// Data converter sequencer: control registers, start logic and the
// 13-cycle ADC / 11-cycle DAC sequences, result and DAC buffer handling.
// Assumes the analog SAR core answers bit decisions on sar_bit_i and that
// the oscillator tick and timer overflows are given on the pins named.
// Operation
// - Two-pin mode set measures positive minus negative pin, else pin versus half supply
// - Channel field picks one of eight pins or one of four pairs
// - Converter powered and operable only while enable bit is set
// - ADC conversion takes 13 converter clocks, sampling in cycle three
// - Completion writes result and sets done flag after synchronisation
// - In ADC mode result registers read-only, held until next completion
// - DAC mode drives differential current on the two output pins from cycle 7 of a conversion until done
// - DAC active when enable and mode set; input settings ignored then
// - DAC mode forces the two output port pins to input-only
// - DAC takes 11 clocks, builds from cycle two, outputs at cycle 7
// - DAC data write-only, buffered at conversion start for its duration
// - Default converter clock is 2 MHz from the 8 MHz oscillator, kept on
// - Otherwise converter clock comes from a 7-bit system clock prescaler
// - Writing start bit while enabled starts one conversion; busy until done
// - Selected timer overflow starts a conversion; hardware drives busy
// - Right align sign extends upper six bits; left align zeroes lower six
// - Mode bit set selects DAC, clear selects ADC
`timescale 1ns/100ps
`default_nettype none
module dcs_sequencer
  import dcs_pkg::*;
#(
  parameter int DATA_BITS = 10
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  input wire logic osc_tick_i,
  input wire logic [2:0] timer_overflow_i,
  input wire logic sar_bit_i,
  output logic converter_power_o,
  output logic osc_keep_on_o,
  output logic adc_mode_o,
  output logic dac_mode_o,
  output logic two_pin_input_mode_o,
  output logic [2:0] positive_pin_o,
  output logic [2:0] negative_pin_o,
  output logic input_connect_o,
  output logic sample_o,
  output logic [DATA_BITS-1:0] sar_trial_o,
  output logic dac_build_o,
  output logic dac_show_o,
  output logic [DATA_BITS-1:0] dac_value_o,
  output logic out_pins_input_only_o,
  output logic conversion_done_o
);
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] input_ctl;
    logic [7:0] data_high;
    logic [7:0] data_low;
    logic [7:0] rdata;
    dcs_state_t fsm;
    logic [3:0] cycle;
    logic [DATA_BITS-1:0] sar;
    logic [DATA_BITS-1:0] dac_buf;
    logic sample;
    logic done_pend;
    logic [1:0] done_sync;
    logic trig_prev;
  } dcs_seq_state_t;

  dcs_seq_state_t state;
  dcs_seq_state_t next_state;
  logic conv_tick;
  logic enabled;
  logic dac_on;
  logic trig_sel;
  logic trig_edge;
  logic sw_start;
  logic [3:0] last_cycle;
  logic [3:0] sar_idx;
  logic [15:0] packed_result;

  // Align a 10-bit two's complement value into the 16-bit pair
  function automatic logic [15:0] dcs_align(input logic [DATA_BITS-1:0] v, input logic left);
    if (left)
      dcs_align = {v, 6'h00};
    else
      dcs_align = {{6{v[DATA_BITS-1]}}, v};
  endfunction : dcs_align

  // Converter clock enable from oscillator or prescaler
  dcs_clock_gen #(
    .PRESCALE_BITS(DCS_PRESCALE_BITS)
  ) u_clock_gen (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .osc_tick_i(osc_tick_i),
    .clock_select_i(state.control[DCS_CTL_CLK_LSB +: 3]),
    .conv_tick_o(conv_tick)
  );

  assign enabled = state.control[DCS_CTL_ENABLE_BIT];
  assign dac_on = enabled && state.control[DCS_CTL_DAC_BIT];
  assign last_cycle = dac_on ? DCS_DAC_CYCLES : DCS_ADC_CYCLES;
  // Bit under trial: sign bit on the tick after the sample, bit 0 on the last tick
  assign sar_idx = DCS_ADC_CYCLES - 4'h1 - state.cycle;
  // Trigger field 0 means software only; 1..3 pick a timer
  assign trig_sel = (state.input_ctl[DCS_IN_TRIG_LSB +: 2] != 2'h0)
                    && timer_overflow_i[state.input_ctl[DCS_IN_TRIG_LSB +: 2] - 2'h1];
  assign trig_edge = trig_sel && !state.trig_prev;
  assign sw_start = reg_write_i && (reg_addr_i == DCS_ADDR_CONTROL)
                    && reg_wdata_i[DCS_CTL_BUSY_BIT];
  assign packed_result = dcs_align(state.sar, state.control[DCS_CTL_LEFT_BIT]);

  // Register port, start handling and conversion sequence
  always_comb
  begin
    next_state = state;
    next_state.trig_prev = trig_sel;
    next_state.done_sync = {state.done_sync[0], 1'b0};
    // Read data stand exactly one cycle after the strobe
    next_state.rdata = 8'h00;
    if (reg_read_i)
    begin
      case (reg_addr_i)
        DCS_ADDR_CONTROL: next_state.rdata = state.control;
        DCS_ADDR_INPUT: next_state.rdata = state.input_ctl;
        // Result pair reads zero in DAC mode; DAC data are write-only
        DCS_ADDR_RESULT_HIGH: next_state.rdata = dac_on ? 8'h00 : state.data_high;
        DCS_ADDR_RESULT_LOW: next_state.rdata = dac_on ? 8'h00 : state.data_low;
        default: next_state.rdata = 8'h00;
      endcase
    end
    if (reg_write_i)
    begin
      case (reg_addr_i)
        DCS_ADDR_CONTROL:
        begin
          // Busy bit is hardware owned; done bit clears by writing zero
          next_state.control[5:0] = reg_wdata_i[5:0];
          if (!reg_wdata_i[DCS_CTL_DONE_BIT])
            next_state.control[DCS_CTL_DONE_BIT] = 1'b0;
        end
        DCS_ADDR_INPUT: next_state.input_ctl = reg_wdata_i;
        // Writes to the pair only land in DAC mode, results are read-only
        DCS_ADDR_RESULT_HIGH: if (dac_on) next_state.data_high = reg_wdata_i;
        DCS_ADDR_RESULT_LOW: if (dac_on) next_state.data_low = reg_wdata_i;
        default: next_state.control = next_state.control;
      endcase
    end
    next_state.sample = 1'b0;
    case (state.fsm)
      DCS_IDLE:
      begin
        // Start only when enabled, from software or timer overflow
        if (enabled && ((sw_start && reg_wdata_i[DCS_CTL_ENABLE_BIT]) || trig_edge))
        begin
          next_state.fsm = DCS_CONVERT;
          next_state.cycle = 4'h0;
          // Signed zero is the offset-binary midpoint, the first trial
          next_state.sar = '0;
          next_state.control[DCS_CTL_BUSY_BIT] = 1'b1;
          // One system clock to capture the DAC buffer at start
          next_state.dac_buf = 10'({state.data_high, state.data_low});
        end
      end
      DCS_CONVERT:
      begin
        // Requests arriving now fall through untouched
        if (conv_tick)
        begin
          next_state.cycle = state.cycle + 4'h1;
          if (!dac_on && (state.cycle + 4'h1 == DCS_ADC_SAMPLE_CYCLE))
            next_state.sample = 1'b1;
          // One decision per tick after the sample; ten ticks give ten bits
          if (!dac_on && (state.cycle + 4'h1 > DCS_ADC_SAMPLE_CYCLE))
          begin
            // Two's complement sign is the inverse of the offset-binary top bit
            next_state.sar[sar_idx] = (sar_idx == 4'(DATA_BITS-1)) ? !sar_bit_i : sar_bit_i;
            if (sar_idx != 4'h0)
              next_state.sar[sar_idx - 4'h1] = 1'b1;
          end
          // DAC steps run on the buffered word from the tick after the build cycle on
          if (dac_on && (state.cycle + 4'h1 > DCS_DAC_BUILD_CYCLE))
            next_state.sar = state.dac_buf;
          if (state.cycle + 4'h1 == last_cycle)
          begin
            next_state.fsm = DCS_FINISH;
            next_state.done_pend = 1'b1;
          end
        end
      end
      DCS_FINISH:
      begin
        // One more converter clock, then two system clocks of sync
        if (conv_tick && state.done_pend)
        begin
          next_state.done_pend = 1'b0;
          next_state.done_sync = {state.done_sync[0], 1'b1};
          if (!dac_on)
          begin
            next_state.data_high = packed_result[15:8];
            next_state.data_low = packed_result[7:0];
          end
        end
        if (state.done_sync[1])
        begin
          next_state.control[DCS_CTL_DONE_BIT] = 1'b1;
          next_state.control[DCS_CTL_BUSY_BIT] = 1'b0;
          next_state.fsm = DCS_IDLE;
        end
      end
      default: next_state.fsm = DCS_IDLE;
    endcase
    // Disable aborts everything with no done flag
    if (!next_state.control[DCS_CTL_ENABLE_BIT])
    begin
      next_state.fsm = DCS_IDLE;
      next_state.control[DCS_CTL_BUSY_BIT] = 1'b0;
      next_state.done_pend = 1'b0;
      next_state.done_sync = 2'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= '0;
      state.control <= DCS_CONTROL_RESET;
      state.input_ctl <= DCS_INPUT_RESET;
      state.fsm <= DCS_IDLE;
    end
    else
      state <= next_state;
  end

  // Analog front-end controls
  assign reg_rdata_o = state.rdata;
  assign converter_power_o = enabled;
  assign osc_keep_on_o = enabled && (state.control[DCS_CTL_CLK_LSB +: 3] == 3'h0);
  assign adc_mode_o = enabled && !state.control[DCS_CTL_DAC_BIT];
  assign dac_mode_o = dac_on;
  assign two_pin_input_mode_o = !dac_on && state.input_ctl[DCS_IN_TWO_PIN_BIT];
  // Pair n uses pins 2n and 2n+1 in two-pin mode
  assign positive_pin_o = state.input_ctl[DCS_IN_TWO_PIN_BIT]
                          ? {state.input_ctl[DCS_IN_CHAN_LSB +: 2], 1'b0}
                          : state.input_ctl[DCS_IN_CHAN_LSB +: 3];
  assign negative_pin_o = {state.input_ctl[DCS_IN_CHAN_LSB +: 2], 1'b1};
  assign input_connect_o = !dac_on && state.input_ctl[DCS_IN_CONNECT_BIT];
  assign sample_o = state.sample;
  assign sar_trial_o = state.sar;
  assign dac_build_o = dac_on && (state.fsm != DCS_IDLE)
                       && (state.cycle + 4'h1 >= DCS_DAC_BUILD_CYCLE);
  assign dac_show_o = dac_on && (state.fsm != DCS_IDLE)
                      && (state.cycle + 4'h1 >= DCS_DAC_SHOW_CYCLE);
  assign dac_value_o = state.dac_buf;
  assign out_pins_input_only_o = dac_on;
  assign conversion_done_o = state.control[DCS_CTL_DONE_BIT];
endmodule : dcs_sequencer
`default_nettype wire

// ===== logic/dcs_pkg.sv
// Package for the data converter sequencer: register map, field layout,
// reset values, timing counts and the sequencer state type.
// Assumes a 100 MHz system clock and an 8-bit software register port.
package dcs_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] DCS_ADDR_CONTROL = 3'h0;
  localparam logic [2:0] DCS_ADDR_INPUT = 3'h1;
  localparam logic [2:0] DCS_ADDR_RESULT_HIGH = 3'h2;
  localparam logic [2:0] DCS_ADDR_RESULT_LOW = 3'h3;
  // Control register fields
  localparam int DCS_CTL_DONE_BIT = 7;
  localparam int DCS_CTL_BUSY_BIT = 6;
  localparam int DCS_CTL_DAC_BIT = 5;
  localparam int DCS_CTL_ENABLE_BIT = 4;
  localparam int DCS_CTL_LEFT_BIT = 3;
  localparam int DCS_CTL_CLK_LSB = 0;
  // Input control register fields
  localparam int DCS_IN_CONNECT_BIT = 7;
  localparam int DCS_IN_TRIG_LSB = 4;
  localparam int DCS_IN_TWO_PIN_BIT = 3;
  localparam int DCS_IN_CHAN_LSB = 0;
  // Reset values
  localparam logic [7:0] DCS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] DCS_INPUT_RESET = 8'h00;
  // Timing counts in converter clocks
  localparam logic [3:0] DCS_ADC_CYCLES = 4'hD;
  localparam logic [3:0] DCS_DAC_CYCLES = 4'hB;
  localparam logic [3:0] DCS_ADC_SAMPLE_CYCLE = 4'h3;
  localparam logic [3:0] DCS_DAC_BUILD_CYCLE = 4'h2;
  localparam logic [3:0] DCS_DAC_SHOW_CYCLE = 4'h7;
  // Clock rates: system and internal oscillator, converter default
  localparam int DCS_SYS_CLK_MHZ = 100;
  localparam int DCS_OSC_MHZ = 8;
  localparam int DCS_DEFAULT_CONV_MHZ = 2;
  localparam int DCS_OSC_DIVIDE = DCS_OSC_MHZ / DCS_DEFAULT_CONV_MHZ;
  localparam int DCS_PRESCALE_BITS = 7;
  // Sequencer states
  typedef enum logic [1:0] {
    DCS_IDLE,
    DCS_CONVERT,
    DCS_FINISH
  } dcs_state_t;
endpackage : dcs_pkg

// ===== logic/dcs_clock_gen.sv
// Converter clock enable generator: picks the internal oscillator divide or
// one tap of a 7-bit system clock prescaler. Oscillator tick arrives on
// its own pin from outside and is synchronised here.
`timescale 1ns/100ps
`default_nettype none
module dcs_clock_gen
  import dcs_pkg::*;
#(
  parameter int PRESCALE_BITS = DCS_PRESCALE_BITS
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic osc_tick_i,
  input wire logic [2:0] clock_select_i,
  output logic conv_tick_o
);
  typedef struct packed {
    logic [PRESCALE_BITS-1:0] prescale;
    logic [2:0] osc_sync;
    logic [1:0] osc_div;
    logic tick;
  } dcs_clk_state_t;

  dcs_clk_state_t state;
  dcs_clk_state_t next_state;
  logic [PRESCALE_BITS-1:0] next_count;
  logic [PRESCALE_BITS-1:0] tap_mask;

  // Low n bits of the prescaler for select n; select 7 keeps all seven
  assign tap_mask = (7'h01 << clock_select_i) - 7'h01;

  // Prescaler free runs; each select 1 to 7 takes the tap whose lower bits all wrap
  always_comb
  begin
    next_state = state;
    next_count = state.prescale + {{(PRESCALE_BITS-1){1'b0}}, 1'b1};
    next_state.prescale = next_count;
    next_state.osc_sync = {state.osc_sync[1:0], osc_tick_i};
    next_state.tick = 1'b0;
    if (clock_select_i == 3'h0)
    begin
      // Oscillator pin rising edge counted when stage two is high and stage three still low
      if (state.osc_sync[1] && !state.osc_sync[2])
      begin
        next_state.osc_div = state.osc_div + 2'h1;
        next_state.tick = (state.osc_div == 2'(DCS_OSC_DIVIDE - 1));
      end
    end
    else
    begin
      // Select n gives fsys / 2^n: tick when the low n prescaler bits are all ones
      next_state.tick = ((state.prescale & tap_mask) == tap_mask);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign conv_tick_o = state.tick;
endmodule : dcs_clock_gen
`default_nettype wire

// ===== tb/dcs_sequencer_props.sv
// Port checker for the data converter sequencer.
// Sees the sequencer ports only; one clock, asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module dcs_sequencer_props
#(
  parameter int DATA_BITS = 10
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic converter_power_o,
  input wire logic adc_mode_o,
  input wire logic dac_mode_o,
  input wire logic sample_o,
  input wire logic dac_build_o,
  input wire logic dac_show_o,
  input wire logic [DATA_BITS-1:0] dac_value_o,
  input wire logic out_pins_input_only_o,
  input wire logic conversion_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Output may show only after the top bits had five ticks to resolve
  sequence s_build_open; $rose(dac_build_o); endsequence
  sequence s_show_quiet; !dac_show_o [*8]; endsequence
  property p_show_late; s_build_open |=> s_show_quiet; endproperty
  a_show_late: assert property (p_show_late) else $error("DAC shown early");
  property p_show_in; dac_show_o |-> dac_build_o && dac_mode_o; endproperty
  a_show_in: assert property (p_show_in) else $error("DAC shown outside build");
  // Buffer must not move while the output is being built
  property p_hold; dac_build_o && $past(dac_build_o) |-> $stable(dac_value_o); endproperty
  a_hold: assert property (p_hold) else $error("DAC buffer moved");
  property p_sample; sample_o |-> converter_power_o && adc_mode_o && !dac_mode_o; endproperty
  a_sample: assert property (p_sample) else $error("sample out of ADC mode");
  property p_pulse; sample_o |=> !sample_o; endproperty
  a_pulse: assert property (p_pulse) else $error("sample too long");
  property p_modes; !(adc_mode_o && dac_mode_o); endproperty
  a_modes: assert property (p_modes) else $error("both modes on");
  property p_pins; out_pins_input_only_o == (dac_mode_o && converter_power_o); endproperty
  a_pins: assert property (p_pins) else $error("output pins not forced");
  property p_done; $rose(conversion_done_o) |-> converter_power_o; endproperty
  a_done: assert property (p_done) else $error("done while disabled");
endmodule : dcs_sequencer_props
bind dcs_sequencer dcs_sequencer_props #(.DATA_BITS(DATA_BITS)) dcs_sequencer_props_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .converter_power_o(converter_power_o),
  .adc_mode_o(adc_mode_o), .dac_mode_o(dac_mode_o), .sample_o(sample_o),
  .dac_build_o(dac_build_o), .dac_show_o(dac_show_o), .dac_value_o(dac_value_o),
  .out_pins_input_only_o(out_pins_input_only_o), .conversion_done_o(conversion_done_o)
);
`default_nettype wire

// ===== tb/dcs_analog_model.sv
// Analog side model: free-running 8 MHz oscillator, timer overflow
// levels on request, and a comparator against a fixed input level.
`timescale 1ns/100ps
`default_nettype none
module dcs_analog_model
#(
  parameter logic signed [9:0] VIN = 10'h0A5
)
(
  input wire logic clk_i,
  input wire logic [2:0] fire_i,
  input wire logic [9:0] trial_i,
  output logic osc_o,
  output logic [2:0] ovf_o,
  output logic sar_o
);
  // Oscillator never stops, whether it is selected or not
  initial osc_o = 1'h0;
  always #62.5 osc_o = !osc_o;
  // Overflow level changes just after an edge; requests spaced by the bench
  initial ovf_o = 3'h0;
  always @(posedge clk_i) ovf_o <= fire_i;
  // Channel pins stay input-only: the model only feeds them a level
  // Comparator keeps a trial bit while the trial is at or below the input
  assign sar_o = ($signed(trial_i) <= VIN);
endmodule : dcs_analog_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the data converter sequencer.
// Assumes a 100 MHz clock; the analog model gives oscillator, overflows, comparator.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dcs_pkg::*;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic we = 1'h0;
  logic re = 1'h0;
  logic [2:0] fire = 3'h0;
  logic seen = 1'h0;
  logic [7:0] rdata, rval;
  logic [9:0] trial, dval;
  logic [2:0] ovf, pos, neg;
  logic osc, sar, power, keep, adc_m, dac_m, two_pin, conn, smp, show, done, pins_in;
  int nsmp = 0, ncyc = 0, t0 = 0;
  int bad_count = 0, cmp_count = 0;
  // Clock, cycle count, sample pulses and DAC output phase seen
  always #5 clk_i = !clk_i;
  always @(posedge clk_i) ncyc <= ncyc + 1;
  always @(posedge clk_i) if (smp === 1'h1) nsmp <= nsmp + 1;
  always @(posedge clk_i) if (show === 1'h1) seen <= 1'h1;
  dcs_sequencer dcs_sequencer_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rdata), .osc_tick_i(osc),
    .timer_overflow_i(ovf), .sar_bit_i(sar), .converter_power_o(power),
    .osc_keep_on_o(keep), .adc_mode_o(adc_m), .dac_mode_o(dac_m),
    .two_pin_input_mode_o(two_pin), .positive_pin_o(pos), .negative_pin_o(neg),
    .input_connect_o(conn), .sample_o(smp), .sar_trial_o(trial), .dac_build_o(),
    .dac_show_o(show), .dac_value_o(dval), .out_pins_input_only_o(pins_in),
    .conversion_done_o(done));
  dcs_analog_model dcs_analog_model_inst (.clk_i(clk_i), .fire_i(fire), .trial_i(trial),
    .osc_o(osc), .ovf_o(ovf), .sar_o(sar));
  task automatic close_out;
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input logic ok);
    cmp_count++;
    if (ok !== 1'h1)
    begin
      bad_count++;
      $display("[ERR] %0t unexpected value", $time);
    end
  endtask : chk
  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'h1;
    @(posedge clk_i);
    we <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    addr <= a;
    re <= 1'h1;
    @(posedge clk_i);
    re <= 1'h0;
    #1;
    rval = rdata;
  endtask : rd
  task automatic go(input logic [7:0] cfg);
    nsmp = 0;
    seen = 1'h0;
    wr(DCS_ADDR_CONTROL, cfg | 8'h40);
    t0 = ncyc;
  endtask : go
  // Bounded wait for completion; elapsed cycles since the start
  task automatic fin(output int el);
    int n;
    for (n = 0; n < 1000 && done !== 1'h1; n++)
      @(posedge clk_i);
    el = ncyc - t0;
    if (n >= 1000)
    begin
      bad_count++;
      $display("[ERR] %0t no completion", $time);
      close_out();
    end
  endtask : fin
  task automatic pulse(input int k);
    @(posedge clk_i);
    fire[k] <= 1'h1;
    repeat (3) @(posedge clk_i);
    fire <= 3'h0;
    t0 = ncyc;
  endtask : pulse
  task automatic t_chan;
    wr(DCS_ADDR_CONTROL, 8'h11);
    wr(DCS_ADDR_INPUT, 8'h0D); // connect off before a channel change
    wr(DCS_ADDR_INPUT, 8'h8D);
    chk(two_pin === 1'h1 && conn === 1'h1);
    chk(pos === 3'h2 && neg === 3'h3);
    wr(DCS_ADDR_INPUT, 8'h05);
    wr(DCS_ADDR_INPUT, 8'h85);
    chk(two_pin === 1'h0 && pos === 3'h5);
  endtask : t_chan
  // One ADC conversion, with a second start while busy
  task automatic t_adc(input logic [7:0] cfg, input int lo, input int hi);
    int el;
    wr(DCS_ADDR_CONTROL, cfg);
    chk(power === 1'h1 && adc_m === 1'h1 && pins_in === 1'h0);
    chk(keep === (cfg[2:0] == 3'h0));
    go(cfg); // input settings left alone until done
    wr(DCS_ADDR_CONTROL, cfg | 8'h40);
    rd(DCS_ADDR_CONTROL);
    chk(rval[6] === 1'h1);
    fin(el);
    chk(el >= lo && el <= hi && nsmp == 1);
    rd(DCS_ADDR_CONTROL);
    chk(rval === (cfg | 8'h80));
  endtask : t_adc
  task automatic t_result;
    logic [7:0] h;
    rd(DCS_ADDR_RESULT_HIGH);
    h = rval;
    chk(h[7:2] === {6{h[1]}});
    wr(DCS_ADDR_RESULT_HIGH, ~h);
    rd(DCS_ADDR_RESULT_HIGH);
    chk(rval === h);
    rd(DCS_ADDR_RESULT_LOW);
    chk(h === 8'h00 && rval === 8'hA5);
  endtask : t_result
  task automatic t_dac;
    int el;
    wr(DCS_ADDR_CONTROL, 8'h31); // fsys/2 stays at or below the CPU clock
    chk(dac_m === 1'h1 && adc_m === 1'h0 && pins_in === 1'h1);
    chk(conn === 1'h0 && two_pin === 1'h0);
    wr(DCS_ADDR_RESULT_HIGH, 8'h02);
    wr(DCS_ADDR_RESULT_LOW, 8'hA5);
    rd(DCS_ADDR_RESULT_HIGH);
    chk(rval === 8'h00);
    go(8'h31);
    wr(DCS_ADDR_RESULT_LOW, 8'h5A);
    fin(el);
    chk(el >= 20 && el <= 40 && seen === 1'h1 && nsmp == 0);
    chk(dval === 10'h2A5);
    rd(DCS_ADDR_CONTROL);
    chk(rval === 8'hB1);
  endtask : t_dac
  task automatic t_abort;
    wr(DCS_ADDR_CONTROL, 8'h11);
    go(8'h11);
    rd(DCS_ADDR_CONTROL);
    chk(rval === 8'h51);
    wr(DCS_ADDR_CONTROL, 8'h01);
    repeat (60) @(posedge clk_i);
    chk(done === 1'h0 && power === 1'h0);
    rd(DCS_ADDR_CONTROL);
    chk(rval === 8'h01);
  endtask : t_abort
  // Each timer source in turn; an unselected overflow must not start
  task automatic t_trig;
    int el;
    for (int t = 1; t < 4; t++)
    begin
      wr(DCS_ADDR_CONTROL, 8'h11);
      wr(DCS_ADDR_INPUT, 8'h80 | 8'(t << 4));
      nsmp = 0;
      pulse(t % 3);
      repeat (60) @(posedge clk_i); // overflows spaced beyond a conversion
      chk(nsmp == 0 && done === 1'h0);
      pulse(t - 1);
      fin(el);
      chk(nsmp == 1 && el <= 40);
      rd(DCS_ADDR_CONTROL);
      chk(rval === 8'h91);
    end
  endtask : t_trig
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rd(DCS_ADDR_CONTROL);
    chk(rval === DCS_CONTROL_RESET && power === 1'h0);
    rd(DCS_ADDR_INPUT);
    chk(rval === DCS_INPUT_RESET);
    t_chan();
    t_adc(8'h11, 24, 44);
    t_result();
    t_adc(8'h12, 44, 80);
    t_adc(8'h10, 280, 800);
    t_adc(8'h19, 24, 44);
    rd(DCS_ADDR_RESULT_LOW);
    chk(rval === 8'h40);
    t_dac();
    t_abort();
    t_trig();
    close_out();
  end
endmodule : testbench
`default_nettype wire
